/* File: bench/flash_err_model.sv */
/*
  Behavioural flash partner: error overlay on reads, status word, clear commands.
  Assumes the bench resolves the data bus from dq_oe and arms one error at a time.
*/
`timescale 1ns/100ps

module flash_err_model
  import err_host_pkg::*;
(
  input wire flash_pins_t pins_in,
  input wire logic arm_in,
  input wire err_class_t kind_in,
  input wire logic erase_in,
  input wire logic susp_in,
  input wire logic last_b7_in,
  input wire logic [DATA_W-1:0] array_in,
  input wire logic [31:0] busy_ns_in,
  input wire logic [31:0] clear_ns_in,
  output logic [DATA_W-1:0] dq_out,
  output logic ready_busy_n_out
);
  err_class_t cur = CLS_NONE;
  logic busy = 1'b0;
  logic sr_next = 1'b0;
  logic tog = 1'b0;
  logic [7:0] w;
  logic [15:0] r;
  logic [15:0] word;
  int ul = 0;
  integer seed = 94655;

  // Open-drain pin with pull-up: low only while busy.
  assign ready_busy_n_out = ~busy;

  // Status word; bits 6 and 0 stay random because the host must not trust them.
  function automatic logic [7:0] stat(input logic [7:0] x);
    case (cur)
      CLS_OP_FAIL: stat = {1'b1, x[6], erase_in, ~erase_in, 3'b000, x[0]};
      CLS_PROT: stat = busy ? {1'b0, x[6:0]} :
        {1'b1, x[6], erase_in, ~erase_in, 3'b001, x[0]};
      CLS_ABORT: stat = {1'b1, x[6], 5'b01100, x[0]};
      default: stat = {1'b1, x[6], 5'b00000, x[0]};
    endcase
  endfunction : stat

  // Polling overlay; bits 4 and 0, and bits 3 and 2 of an abort without suspend, are random so a host that forgets a mask is caught.
  function automatic logic [7:0] poll(input logic [7:0] x);
    logic ab;
    ab = (cur == CLS_ABORT);
    poll[7] = (erase_in && !ab) ? 1'b0 : ~last_b7_in;
    poll[6] = tog;
    poll[5] = (cur == CLS_OP_FAIL);
    poll[4] = x[4];
    poll[3] = (ab && !susp_in) ? x[3] : 1'b1;
    poll[2] = (ab && !susp_in) ? x[2] : tog;
    poll[1] = ab;
    poll[0] = x[0];
  endfunction : poll

  // An armed error makes the part busy; a protection error ends by itself.
  always @(posedge arm_in)
  begin
    cur = kind_in;
    tog = 1'b0;
    busy = (kind_in != CLS_NONE);
    if (kind_in == CLS_PROT)
    begin
      #(busy_ns_in);
      busy = 1'b0;
    end
  end

  // Commands land on the rising write strobe; others are ignored during an error.
  always @(posedge pins_in.we_n)
  begin
    if (!pins_in.ce_n)
    begin
      w = pins_in.dq[7:0];
      if (pins_in.dq == CMD_SR_READ && pins_in.addr == ADDR_UNLOCK1)
        sr_next = 1'b1;
      else if (busy && cur != CLS_PROT && (w == CMD_SR_CLEAR[7:0] ||
               (w == CMD_RESET[7:0] && (cur == CLS_OP_FAIL || ul == 2))))
      begin
        #(clear_ns_in);
        busy = 1'b0;
        cur = CLS_NONE;
      end
      ul = (w == CMD_UNLOCK1[7:0]) ? 1 : ((w == CMD_UNLOCK2[7:0] && ul == 1) ? 2 : 0);
    end
  end

  // Reads: status once after its command, else overlay while busy, else array data.
  always @(negedge pins_in.oe_n)
  begin
    if (!pins_in.ce_n)
    begin
      r = 16'($random(seed));
      if (sr_next)
        word = {r[15:8], stat(r[7:0])};
      else if (busy)
      begin
        word = {r[15:8], poll(r[7:0])};
        tog = ~tog;
      end
      else
        word = array_in;
      sr_next = 1'b0;
      dq_out = ~dq_out;
      dq_out <= #50 word;
    end
  end

  // A released bus shows the inverse of the last value, never a held copy.
  always @(posedge pins_in.oe_n)
    dq_out = ~dq_out;
endmodule : flash_err_model

/* File: bench/test_err_recovery_host.sv */
/*
  Self-checking bench for the host error recovery controller with a flash partner model.
  Assumes the package constants; the data bus is resolved here from dq_oe.
*/
`timescale 1ns/100ps

module test_err_recovery_host
  import err_host_pkg::*;
  ;
  typedef struct packed {
    err_class_t cls;
    logic [7:0] st;
    logic [7:0] po;
    logic chk;
    logic rb;
  } expect_t;

  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic start_in = 1'b0;
  logic susp = 1'b0;
  logic arm = 1'b0;
  logic erase = 1'b0;
  logic last_b7 = 1'b0;
  err_class_t kind = CLS_NONE;
  logic [DATA_W-1:0] arr = 16'h0000;
  logic [31:0] busy_ns = 32'h0;
  logic [31:0] clear_ns = 32'h0;
  logic rb;
  logic done;
  logic [DATA_W-1:0] mdl_dq;
  logic [DATA_W-1:0] dq_bus;
  flash_pins_t pins;
  err_class_t cls;
  logic [7:0] st;
  logic [7:0] po;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  integer seed = 94655;
  expect_t exp_q[$];
  expect_t e;

  // 200 MHz clock; the host drives dq only while dq_oe is high.
  always #2.5 clk_in = ~clk_in;
  assign dq_bus = pins.dq_oe ? pins.dq : mdl_dq;

  err_recovery_host #(.PROT_MAX_CYCLES(8000)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in), .erase_suspended_in(susp),
    .ready_busy_n_output_in(rb), .dq_in(dq_bus), .pins_out(pins), .done_out(done),
    .class_out(cls), .status_out(st), .poll_out(po));

  flash_err_model i_flash (
    .pins_in(pins), .arm_in(arm), .kind_in(kind), .erase_in(erase), .susp_in(susp),
    .last_b7_in(last_b7), .array_in(arr), .busy_ns_in(busy_ns), .clear_ns_in(clear_ns),
    .dq_out(mdl_dq), .ready_busy_n_out(rb));

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (!ok)
    begin
      mismatches++;
      $display("FAIL at %0t: %s", $time, what);
    end
  endtask : check

  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // Arms one error in the model, notes the expected outcome, then starts the host.
  task automatic run_case(input err_class_t k, input logic [31:0] bns, input err_class_t want);
    expect_t x;
    logic [7:0] mask;
    logic [31:0] r;
    @(posedge clk_in);
    #1;
    r = $random(seed);
    kind = k;
    busy_ns = bns;
    erase = r[0];
    susp = r[1];
    last_b7 = r[2];
    arr = r[31:16];
    clear_ns = {22'h0, r[12:3]};
    arm = 1'b1;
    mask = r[1] ? POLL_KEEP : POLL_KEEP_NOSUSP;
    x.cls = want;
    x.rb = (want != CLS_TIMEOUT);
    x.chk = (want != CLS_TIMEOUT);
    x.st = 8'h80;
    x.po = arr[7:0] & mask;
    if (k != CLS_NONE)
      x.po = {(r[0] && k != CLS_ABORT) ? 1'b0 : ~r[2], 1'b0, k == CLS_OP_FAIL, 3'b010,
              k == CLS_ABORT, 1'b0} & mask;
    if (k == CLS_OP_FAIL)
      x.st = {2'b10, r[0], ~r[0], 4'h0};
    if (k == CLS_PROT)
      x.st = {2'b10, r[0], ~r[0], 4'h2};
    if (k == CLS_ABORT)
      x.st = 8'h98;
    exp_q.push_back(x);
    @(posedge clk_in);
    #1;
    arm = 1'b0;
    start_in = 1'b1;
    repeat (1 + r[14:13]) @(posedge clk_in);
    #1;
    start_in = 1'b0;
    @(posedge clk_in iff done === 1'b1);
    $display("Case %s finished", want.name());
  endtask : run_case

  // Long protection case runs last, its busy time outlives the run.
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (4) @(posedge clk_in);
    run_case(CLS_NONE, 32'd0, CLS_NONE);
    repeat (3)
    begin
      run_case(CLS_OP_FAIL, 32'd0, CLS_OP_FAIL);
      run_case(CLS_ABORT, 32'd0, CLS_ABORT);
    end
    run_case(CLS_PROT, 32'(PROT_MIN_NS), CLS_PROT);
    run_case(CLS_PROT, 32'(PROT_MAX_NS), CLS_TIMEOUT);
    repeat (4) @(posedge clk_in);
    test_done();
  end

  // Monitor: the oldest note is compared each time done pulses; also the hang limit.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      $display("FAIL at %0t: run did not finish", $time);
      test_done();
    end
    if (done === 1'b1)
    begin
      e = exp_q.pop_front();
      check(cls === e.cls, "error class");
      check(rb === e.rb, "ready pin after done");
      if (e.chk)
      begin
        check(st === e.st, "status word");
        check(po === e.po, "polling word");
      end
    end
  end
endmodule : test_err_recovery_host

/* File: rtl/err_host_pkg.sv */
/*
  Shared types and constants for the host-side flash error recovery controller:
  pin bundle, cycle request, command words, status bit positions and timing.
  Assumes a 200 MHz system clock and a word-wide asynchronous flash bus.
*/
package err_host_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // Clock period and bus timing, in picoseconds and nanoseconds.
  localparam int CLK_PS = 5000;
  localparam int STROBE_NS = 70;
  localparam int RECOV_NS = 20;
  localparam int SYNC_LAT = 2;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_LAT;
  localparam int RECOV_CYC = (RECOV_NS * 1000 + CLK_PS - 1) / CLK_PS;

  // Protection busy window: least time rounds up, longest rounds down.
  localparam int PROT_MIN_NS = 20000;
  localparam int PROT_MAX_NS = 100000;
  localparam int PROT_MIN_CYC = (PROT_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PROT_MAX_CYC = (PROT_MAX_NS * 1000) / CLK_PS;

  // Command addresses and data words.
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 22'h000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 22'h0002AA;
  localparam logic [ADDR_W-1:0] ADDR_ANY = 22'h000000;
  localparam logic [DATA_W-1:0] CMD_SR_READ = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_SR_CLEAR = 16'h0071;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;

  // Bit positions in operation_status and in the polling word.
  localparam int SR_VALID = 7;
  localparam int SR_SUSP = 6;
  localparam int SR_ERASE = 5;
  localparam int SR_PROG = 4;
  localparam int SR_ABORT = 3;
  localparam int SR_PROT = 1;
  localparam int SR_RSVD = 0;
  localparam int DQ_ERASE_TIMER = 3;
  localparam int DQ_SECOND_TOGGLE = 2;
  localparam int DQ_RSVD_HI = 4;
  localparam int DQ_RSVD_LO = 0;

  localparam logic [7:0] POLL_KEEP = 8'hEE;
  localparam logic [7:0] POLL_KEEP_NOSUSP = 8'hE2;
  localparam logic [7:0] SR_KEEP = 8'hBE;

  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_OP_FAIL = 3'h1,
    CLS_PROT = 3'h2,
    CLS_ABORT = 3'h3,
    CLS_TIMEOUT = 3'h4
  } err_class_t;

  // Pins driven toward the flash; dq_oe is high while the host drives dq.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
  } flash_pins_t;

  // One bus cycle request; go is a one-cycle pulse.
  typedef struct packed {
    logic go;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cyc_req_t;

endpackage : err_host_pkg

/* File: rtl/err_recovery_host.sv */
/*
  Host-side error recovery controller for a parallel NOR flash. On a user start
  it takes one polling read, reads operation_status, classifies the error and
  issues the clear for a failure or an abort, then waits for ready_busy_n_output to go high.
  Assumes the flash pins are asynchronous to clk_in; the board resolves dq from dq_oe.
*/
`timescale 1ns/100ps

// Operation
// - Only status read, reset, clear during failure.
// - Only status read during protection busy.
// - Mask erase timer, second toggle unless suspended.
// - Abort cleared by abort-reset or status clear.
// - Host masks reserved polling and status bits.
module err_recovery_host
  import err_host_pkg::*;
#(
  parameter int PROT_MAX_CYCLES = PROT_MAX_CYC
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic erase_suspended_in,
  input wire logic ready_busy_n_output_in,
  input wire logic [DATA_W-1:0] dq_in,
  output flash_pins_t pins_out,
  output logic done_out,
  output err_class_t class_out,
  output logic [7:0] status_out,
  output logic [7:0] poll_out
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_POLL = 4'h1,
    ST_SRCMD = 4'h3,
    ST_SRRD = 4'h2,
    ST_DECIDE = 4'h6,
    ST_CLR = 4'h7,
    ST_ABT1 = 4'h5,
    ST_ABT2 = 4'h4,
    ST_ABT3 = 4'hC,
    ST_RDYW = 4'hD,
    ST_DONE = 4'hF,
    ST_PWAIT = 4'hE
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic wait_cyc;
    cyc_req_t req;
    logic [7:0] sr;
    logic [7:0] poll;
    err_class_t cls;
    logic [15:0] cnt;
    logic [15:0] tot;
    logic done;
    logic rb_meta;
    logic rb_sync;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
  } ctl_t;

  localparam cyc_req_t REQ_IDLE = '{go: 1'b0, wr: 1'b0, addr: '0, wdata: '0};
  localparam ctl_t CTL_RST = '{st: ST_IDLE, wait_cyc: 1'b0, req: REQ_IDLE, sr: '0, poll: '0,
                               cls: CLS_NONE, cnt: '0, tot: '0, done: 1'b0,
                               rb_meta: 1'b0, rb_sync: 1'b0, dq_meta: '0, dq_sync: '0};

  logic rst_meta;
  logic rst_n;
  ctl_t c_r;
  ctl_t c_nxt;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  // Builds a one-cycle bus cycle request.
  function automatic cyc_req_t mk_req(input logic wr, input logic [ADDR_W-1:0] a,
                                      input logic [DATA_W-1:0] d);
    mk_req = '{go: 1'b1, wr: wr, addr: a, wdata: d};
  endfunction : mk_req

  // Reset is released through two flip-flops so every flop leaves reset together.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  flash_cycle u_cycle (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .req_in(c_r.req),
    .dq_sync_in(c_r.dq_sync),
    .pins_out(pins_out),
    .rdata_out(cyc_rdata),
    .done_out(cyc_done)
  );

  // Sequencer. A step that issues a bus cycle then waits for it in wait_cyc.
  always_comb
  begin
    c_nxt = c_r;
    c_nxt.req = REQ_IDLE;
    c_nxt.done = 1'b0;
    c_nxt.rb_meta = ready_busy_n_output_in;
    c_nxt.rb_sync = c_r.rb_meta;
    c_nxt.dq_meta = dq_in;
    c_nxt.dq_sync = c_r.dq_meta;
    if (c_r.wait_cyc)
    begin
      if (cyc_done)
      begin
        c_nxt.wait_cyc = 1'b0;
      end
    end
    else
    begin
      unique case (c_r.st)
        ST_IDLE:
        begin
          if (start_in)
          begin
            c_nxt.tot = '0;
            c_nxt.cls = CLS_NONE;
            c_nxt.req = mk_req(1'b0, ADDR_ANY, '0);
            c_nxt.wait_cyc = 1'b1;
            c_nxt.st = ST_POLL;
          end
        end
        ST_POLL:
        begin
          // Reserved polling bits always masked; erase timer and second toggle kept
          // only when an erase was suspended before the aborted program.
          c_nxt.poll = cyc_rdata[7:0] &
                       (erase_suspended_in ? POLL_KEEP : POLL_KEEP_NOSUSP);
          c_nxt.req = mk_req(1'b1, ADDR_UNLOCK1, CMD_SR_READ);
          c_nxt.wait_cyc = 1'b1;
          c_nxt.st = ST_SRCMD;
        end
        ST_SRCMD:
        begin
          c_nxt.req = mk_req(1'b0, ADDR_ANY, '0);
          c_nxt.wait_cyc = 1'b1;
          c_nxt.st = ST_SRRD;
        end
        ST_SRRD:
        begin
          c_nxt.sr = cyc_rdata[7:0] & SR_KEEP;
          c_nxt.st = ST_DECIDE;
        end
        ST_DECIDE:
        begin
          // Abort is tested before the failure bits because abort also sets bit 4.
          if (!c_r.sr[SR_VALID])
          begin
            c_nxt.cls = CLS_PROT;
            c_nxt.cnt = 16'(PROT_MIN_CYC);
            c_nxt.st = ST_PWAIT;
          end
          else if (c_r.sr[SR_ABORT])
          begin
            c_nxt.cls = CLS_ABORT;
            c_nxt.req = mk_req(1'b1, ADDR_UNLOCK1, CMD_UNLOCK1);
            c_nxt.wait_cyc = 1'b1;
            c_nxt.st = ST_ABT1;
          end
          else if (c_r.sr[SR_PROT])
          begin
            c_nxt.cls = CLS_PROT;
            c_nxt.done = 1'b1;
            c_nxt.st = ST_IDLE;
          end
          else if (c_r.sr[SR_ERASE] || c_r.sr[SR_PROG])
          begin
            c_nxt.cls = CLS_OP_FAIL;
            c_nxt.req = mk_req(1'b1, ADDR_UNLOCK1, CMD_SR_CLEAR);
            c_nxt.wait_cyc = 1'b1;
            c_nxt.st = ST_CLR;
          end
          else
          begin
            c_nxt.done = 1'b1;
            c_nxt.st = ST_IDLE;
          end
        end
        ST_PWAIT:
        begin
          // Only status reads are sent while the protection window may still run.
          if (c_r.tot >= 16'(PROT_MAX_CYCLES))
          begin
            c_nxt.cls = CLS_TIMEOUT;
            c_nxt.done = 1'b1;
            c_nxt.st = ST_IDLE;
          end
          else if (c_r.cnt == 16'h0000)
          begin
            c_nxt.req = mk_req(1'b1, ADDR_UNLOCK1, CMD_SR_READ);
            c_nxt.wait_cyc = 1'b1;
            c_nxt.st = ST_SRCMD;
          end
          else
          begin
            c_nxt.cnt = c_r.cnt - 16'h0001;
            c_nxt.tot = c_r.tot + 16'h0001;
          end
        end
        ST_ABT1:
        begin
          c_nxt.req = mk_req(1'b1, ADDR_UNLOCK2, CMD_UNLOCK2);
          c_nxt.wait_cyc = 1'b1;
          c_nxt.st = ST_ABT2;
        end
        ST_ABT2:
        begin
          c_nxt.req = mk_req(1'b1, ADDR_UNLOCK1, CMD_RESET);
          c_nxt.wait_cyc = 1'b1;
          c_nxt.st = ST_ABT3;
        end
        ST_ABT3, ST_CLR:
        begin
          c_nxt.tot = '0;
          c_nxt.st = ST_RDYW;
        end
        ST_RDYW:
        begin
          // The clear must release ready_busy_n_output; a stuck pin ends in timeout.
          if (c_r.rb_sync)
          begin
            c_nxt.done = 1'b1;
            c_nxt.st = ST_IDLE;
          end
          else if (c_r.tot >= 16'(PROT_MAX_CYCLES))
          begin
            c_nxt.cls = CLS_TIMEOUT;
            c_nxt.done = 1'b1;
            c_nxt.st = ST_IDLE;
          end
          else
          begin
            c_nxt.tot = c_r.tot + 16'h0001;
          end
        end
        ST_DONE:
        begin
          c_nxt.st = ST_IDLE;
        end
        default:
        begin
          c_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_r <= CTL_RST;
    end
    else
    begin
      c_r <= c_nxt;
    end
  end

  assign done_out = c_r.done;
  assign class_out = c_r.cls;
  assign status_out = c_r.sr;
  assign poll_out = c_r.poll;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  // The request leaves the wait state already registered, so the class is watched instead.
  prot_read_only_a: assert property (c_r.cls == CLS_PROT && c_r.req.go &&
    c_r.req.wr |-> c_r.req.addr == ADDR_UNLOCK1 && c_r.req.wdata == CMD_SR_READ)
    else $error("non status-read command during protection busy");
  abort_clear_a: assert property (c_r.st == ST_DECIDE && !c_r.wait_cyc &&
    c_r.sr[SR_VALID] && c_r.sr[SR_ABORT] |=> c_r.st == ST_ABT1 && c_r.cls == CLS_ABORT)
    else $error("buffer abort not routed to abort reset");
  fail_clear_a: assert property (c_r.st == ST_DECIDE && !c_r.wait_cyc &&
    c_r.sr[SR_VALID] && !c_r.sr[SR_ABORT] && !c_r.sr[SR_PROT] && c_r.sr[SR_PROG]
    |=> c_r.req.go && c_r.req.wdata == CMD_SR_CLEAR)
    else $error("operation failure not cleared by status clear");
  abort_seq_a: assert property (c_r.st == ST_ABT3 && c_r.req.go |->
    c_r.req.addr == ADDR_UNLOCK1 && c_r.req.wdata == CMD_RESET)
    else $error("abort reset sequence ends with wrong word");
  mask_rsvd_a: assert property (!c_r.sr[SR_RSVD] && !c_r.sr[SR_SUSP] &&
    !c_r.poll[DQ_RSVD_HI] && !c_r.poll[DQ_RSVD_LO])
    else $error("reserved bits not masked");
  mask_susp_a: assert property ($rose(c_r.st == ST_SRCMD) &&
    $past(c_r.st) == ST_POLL && !$past(erase_suspended_in) |->
    c_r.poll[DQ_ERASE_TIMER:DQ_SECOND_TOGGLE] == 2'b00)
    else $error("erase timer or second toggle not masked");
  prot_done_a: assert property (c_r.st == ST_DECIDE && !c_r.wait_cyc &&
    c_r.sr[SR_VALID] && !c_r.sr[SR_ABORT] && c_r.sr[SR_PROT]
    |=> c_r.done && c_r.cls == CLS_PROT && !c_r.req.go)
    else $error("protection error issued a clear");
  ready_done_a: assert property (c_r.st == ST_RDYW && !c_r.wait_cyc && c_r.rb_sync
    |=> done_out ##1 !done_out)
    else $error("ready not reported as one-cycle done");

endmodule : err_recovery_host

/* File: rtl/flash_cycle.sv */
/*
  Single asynchronous flash bus cycle engine: one write or one read per request.
  Assumes dq_sync_in is already passed through two flip-flops by the caller.
*/
`timescale 1ns/100ps

module flash_cycle
  import err_host_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire cyc_req_t req_in,
  input wire logic [DATA_W-1:0] dq_sync_in,
  output flash_pins_t pins_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic done_out
);

  typedef enum logic [1:0] {
    CY_IDLE = 2'h0,
    CY_ACT = 2'h1,
    CY_REC = 2'h3
  } cyc_state_t;

  typedef struct packed {
    cyc_state_t st;
    flash_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic [7:0] cnt;
    logic done;
  } cyc_t;

  localparam cyc_t CYC_RST = '{st: CY_IDLE,
                               pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                       addr: '0, dq: '0, dq_oe: 1'b0},
                               rdata: '0, cnt: '0, done: 1'b0};

  cyc_t c_r;
  cyc_t c_nxt;

  // Strobe is held long enough for access time plus the input synchroniser delay.
  always_comb
  begin
    c_nxt = c_r;
    c_nxt.done = 1'b0;
    unique case (c_r.st)
      CY_IDLE:
      begin
        if (req_in.go)
        begin
          c_nxt.pins.addr = req_in.addr;
          c_nxt.pins.dq = req_in.wdata;
          c_nxt.pins.dq_oe = req_in.wr;
          c_nxt.pins.ce_n = 1'b0;
          c_nxt.pins.we_n = ~req_in.wr;
          c_nxt.pins.oe_n = req_in.wr;
          c_nxt.cnt = 8'(STROBE_CYC);
          c_nxt.st = CY_ACT;
        end
      end
      CY_ACT:
      begin
        if (c_r.cnt == 8'h00)
        begin
          if (!c_r.pins.dq_oe)
          begin
            c_nxt.rdata = dq_sync_in;
          end
          c_nxt.pins.we_n = 1'b1;
          c_nxt.pins.oe_n = 1'b1;
          c_nxt.cnt = 8'(RECOV_CYC);
          c_nxt.st = CY_REC;
        end
        else
        begin
          c_nxt.cnt = c_r.cnt - 8'h01;
        end
      end
      CY_REC:
      begin
        // Data stays driven past the write strobe edge to meet hold time.
        if (c_r.cnt == 8'h00)
        begin
          c_nxt.pins.ce_n = 1'b1;
          c_nxt.pins.dq_oe = 1'b0;
          c_nxt.done = 1'b1;
          c_nxt.st = CY_IDLE;
        end
        else
        begin
          c_nxt.cnt = c_r.cnt - 8'h01;
        end
      end
      default:
      begin
        c_nxt = CYC_RST;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      c_r <= CYC_RST;
    end
    else
    begin
      c_r <= c_nxt;
    end
  end

  assign pins_out = c_r.pins;
  assign rdata_out = c_r.rdata;
  assign done_out = c_r.done;

endmodule : flash_cycle
